// *** pkg/cflp_pkg.sv ***
// Constants, register map and mode encoding for the link-fault pass-through block
package cflp_pkg;

   // ----------------------------------------------------------------
   // Sizes and timing
   // ----------------------------------------------------------------
   localparam int          CFLP_NUM_CH        = 12;
   localparam int          CFLP_ADDR_W        = 8;
   localparam int          CFLP_DATA_W        = 32;
   localparam int          CFLP_REF_CLK_HZ    = 25_000_000;
   localparam int          CFLP_BLINK_MS      = 1000;
   // Half of the blink period in clock cycles, rounded down
   localparam int          CFLP_HALF_CYC      = CFLP_REF_CLK_HZ / 1000 * CFLP_BLINK_MS / 2;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0]  CFLP_ADDR_MODE     = 8'h00;
   localparam logic [7:0]  CFLP_ADDR_LINK     = 8'h04;
   localparam logic [7:0]  CFLP_ADDR_EVENT    = 8'h08;
   localparam logic [7:0]  CFLP_ADDR_MASK     = 8'h0c;
   localparam int          CFLP_MODE_FLD_W    = 2;
   localparam int          CFLP_LINK_FI_POS   = 16;
   localparam logic [31:0] CFLP_RESET_WORD    = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Channel operating modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CFLP_MODE_DISPLAY           = 2'b00,
      CFLP_MODE_LOSS_SILENCE      = 2'b01,
      CFLP_MODE_LOSS_PULSE        = 2'b10,
      CFLP_MODE_ILLEGAL           = 2'b11
   } cflp_mode_t;

endpackage

// *** hdl/cflp_blink_timer.sv ***
// Per-channel blink prescaler producing the pulse and blink phase
`timescale 1ns/1ns
`default_nettype none
module cflp_blink_timer
   import cflp_pkg::*;
#(
   parameter int HALF_CYC = CFLP_HALF_CYC
)(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Control
   input  wire logic restart,
   // Phase out, high while the transmitter may run
   output var  logic blinkOn
);

   localparam int CW = $clog2(HALF_CYC + 1);

   typedef struct packed {
      logic [CW-1:0] count;
      logic          phase;
   } cflp_timer_t;

   cflp_timer_t q;
   cflp_timer_t d;

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Restart begins with the dark half so the far end sees a loss at once
   always_comb
   begin
      d = q;
      if (restart)
      begin
         d.count = '0;
         d.phase = 1'b0;
      end
      else if (q.count == CW'(HALF_CYC - 1))
      begin
         d.count = '0;
         d.phase = ~q.phase;
      end
      else
      begin
         d.count = q.count + CW'(1);
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign blinkOn = q.phase;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_restart_dark: assert property (
      restart |=> !blinkOn && q.count == '0)
      else $error("blink phase not restarted dark");

endmodule // cflp_blink_timer
`default_nettype wire

// *** hdl/channel_link_fault_passthrough.sv ***
// Link-fault pass-through controller for a bank of copper/fiber channels
`timescale 1ns/1ns
`default_nettype none
module channel_link_fault_passthrough
   import cflp_pkg::*;
#(
   parameter int NUM_CH   = CFLP_NUM_CH,
   parameter int HALF_CYC = CFLP_HALF_CYC
)(
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   // Register port
   input  wire logic [CFLP_ADDR_W-1:0] regAddr,
   input  wire logic [CFLP_DATA_W-1:0] regWrData,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   output var  logic [CFLP_DATA_W-1:0] regRdData,
   output var  logic                   irq,
   // Port PHY link status pins, asynchronous
   input  wire logic [NUM_CH-1:0]      cuLinkIn,
   input  wire logic [NUM_CH-1:0]      fiLinkIn,
   // Front-panel mode buttons, one per channel, asynchronous
   input  wire logic [NUM_CH-1:0]      modeBtnIn,
   // Transmitter enables and Link LEDs
   output var  logic [NUM_CH-1:0]      cuTxEn,
   output var  logic [NUM_CH-1:0]      fiTxEn,
   output var  logic [NUM_CH-1:0]      cuLinkLed,
   output var  logic [NUM_CH-1:0]      fiLinkLed
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NUM_CH-1:0]   cuMeta;
      logic [NUM_CH-1:0]   cuSync;
      logic [NUM_CH-1:0]   cuPrev;
      logic [NUM_CH-1:0]   fiMeta;
      logic [NUM_CH-1:0]   fiSync;
      logic [NUM_CH-1:0]   fiPrev;
      logic [NUM_CH-1:0]   btnMeta;
      logic [NUM_CH-1:0]   btnSync;
      logic [NUM_CH-1:0]   btnPrev;
      logic [NUM_CH-1:0]   pulsePrev;
      logic [2*NUM_CH-1:0] mode;
      logic [NUM_CH-1:0]   evt;
      logic [NUM_CH-1:0]   mask;
      logic [NUM_CH-1:0]   cuTx;
      logic [NUM_CH-1:0]   fiTx;
      logic [NUM_CH-1:0]   cuLed;
      logic [NUM_CH-1:0]   fiLed;
      logic                irq;
      logic [31:0]         rdData;
   } cflp_main_t;

   cflp_main_t        q;
   cflp_main_t        d;
   logic [NUM_CH-1:0] pulseNow;
   logic [NUM_CH-1:0] blinkRestart;
   logic [NUM_CH-1:0] blinkOn;
   logic [NUM_CH-1:0] blinkPh;
   logic              cu;
   logic              fi;
   logic              modeWrite;
   logic [1:0]        wrField;
   cflp_mode_t        m;

   // Mode field of one channel
   function automatic cflp_mode_t chMode(input logic [2*NUM_CH-1:0] v, input int ch);
      chMode = cflp_mode_t'(v[CFLP_MODE_FLD_W*ch +: CFLP_MODE_FLD_W]);
   endfunction

   // Button steps through the three legal modes in turn
   function automatic cflp_mode_t stepMode(input cflp_mode_t cur);
      case (cur)
         CFLP_MODE_DISPLAY:      stepMode = CFLP_MODE_LOSS_SILENCE;
         CFLP_MODE_LOSS_SILENCE: stepMode = CFLP_MODE_LOSS_PULSE;
         default:                stepMode = CFLP_MODE_DISPLAY;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Blink prescalers, one per channel
   // ----------------------------------------------------------------
   // Restart on the cycle the channel enters pulsing
   assign blinkRestart = pulseNow & ~q.pulsePrev;

   // Split pair in pulse mode; kept out of the main process so the
   // restart path cannot loop back through the next-state logic
   always_comb
   begin
      pulseNow = '0;
      for (int c = 0; c < NUM_CH; c++)
         pulseNow[c] = (chMode(q.mode, c) == CFLP_MODE_LOSS_PULSE)
                     && (q.cuSync[c] ^ q.fiSync[c]);
   end

   // Timer still shows its old phase on the restart cycle, so force it dark
   assign blinkPh = blinkOn & ~blinkRestart;

   generate
      for (genvar g = 0; g < NUM_CH; g++)
      begin : gTimer
         cflp_blink_timer #(
            .HALF_CYC (HALF_CYC)
         ) uTimer (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .restart  (blinkRestart[g]),
            .blinkOn  (blinkOn[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Sync first stages feed only the second stages
   always_comb
   begin
      d         = q;
      cu        = 1'b0;
      fi        = 1'b0;
      m         = CFLP_MODE_DISPLAY;
      wrField   = 2'b00;
      modeWrite = regWrite && (regAddr == CFLP_ADDR_MODE);
      d.cuMeta  = cuLinkIn;
      d.cuSync  = q.cuMeta;
      d.cuPrev  = q.cuSync;
      d.fiMeta  = fiLinkIn;
      d.fiSync  = q.fiMeta;
      d.fiPrev  = q.fiSync;
      d.btnMeta = modeBtnIn;
      d.btnSync = q.btnMeta;
      d.btnPrev = q.btnSync;

      for (int c = 0; c < NUM_CH; c++)
      begin
         m       = chMode(q.mode, c);
         cu      = q.cuSync[c];
         fi      = q.fiSync[c];
         wrField = regWrData[CFLP_MODE_FLD_W*c +: CFLP_MODE_FLD_W];

         // A register write with a legal code beats a button press in the same cycle;
         // the unused code is refused so only three modes exist
         if (modeWrite && wrField != CFLP_MODE_ILLEGAL)
            d.mode[CFLP_MODE_FLD_W*c +: CFLP_MODE_FLD_W] = wrField;
         else if (q.btnSync[c] && !q.btnPrev[c])
            d.mode[CFLP_MODE_FLD_W*c +: CFLP_MODE_FLD_W] = stepMode(m);

         // Per-mode transmitter and LED drive
         case (m)
            CFLP_MODE_LOSS_SILENCE:
            begin
               d.fiTx[c]  = cu;
               d.cuTx[c]  = fi;
               d.cuLed[c] = cu & fi;
               d.fiLed[c] = cu & fi;
            end
            CFLP_MODE_LOSS_PULSE:
            begin
               // Side that still has its link pulses; a dead side stays dark
               d.fiTx[c]  = cu | ~fi ? 1'b1 : blinkPh[c];
               d.cuTx[c]  = fi | ~cu ? 1'b1 : blinkPh[c];
               if (!cu && fi)
                  d.fiTx[c] = blinkPh[c];
               d.cuLed[c] = cu & (fi | blinkPh[c]);
               d.fiLed[c] = fi & (cu | blinkPh[c]);
            end
            default:
            begin
               d.cuTx[c]  = 1'b1;
               d.fiTx[c]  = 1'b1;
               d.cuLed[c] = cu;
               d.fiLed[c] = fi;
            end
         endcase

         // Any link change is an event; a set beats a read clear
         d.evt[c] = (q.evt[c] & ~(regRead && regAddr == CFLP_ADDR_EVENT))
                  | (cu ^ q.cuPrev[c]) | (fi ^ q.fiPrev[c]);
      end
      d.pulsePrev = pulseNow;

      if (regWrite && regAddr == CFLP_ADDR_MASK)
         d.mask = regWrData[NUM_CH-1:0];

      // Read data stand for exactly one cycle
      d.rdData = CFLP_RESET_WORD;
      if (regRead)
      begin
         case (regAddr)
            CFLP_ADDR_MODE:  d.rdData[2*NUM_CH-1:0] = q.mode;
            CFLP_ADDR_LINK:
            begin
               d.rdData[NUM_CH-1:0] = q.cuSync;
               d.rdData[CFLP_LINK_FI_POS +: NUM_CH] = q.fiSync;
            end
            CFLP_ADDR_EVENT: d.rdData[NUM_CH-1:0] = q.evt;
            CFLP_ADDR_MASK:  d.rdData[NUM_CH-1:0] = q.mask;
            default:         d.rdData = CFLP_RESET_WORD;
         endcase
      end

      d.irq = |(d.evt & d.mask);
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // Outputs, all straight from flops
   // ----------------------------------------------------------------
   assign regRdData = q.rdData;
   assign irq       = q.irq;
   assign cuTxEn    = q.cuTx;
   assign fiTxEn    = q.fiTx;
   assign cuLinkLed = q.cuLed;
   assign fiLinkLed = q.fiLed;

   // ----------------------------------------------------------------
   // Checks, channel 0 stands for all except a_mode_legal, which scans every channel
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic       anyIllegal;
   cflp_mode_t m0;

   always_comb
   begin
      anyIllegal = 1'b0;
      for (int c = 0; c < NUM_CH; c++)
         anyIllegal = anyIllegal | (chMode(q.mode, c) == CFLP_MODE_ILLEGAL);
   end
   assign m0 = chMode(q.mode, 0);

   a_mode_legal: assert property (
      !anyIllegal)
      else $error("channel holds an illegal mode");

   a_mode_write: assert property (
      regWrite && regAddr == CFLP_ADDR_MODE && regWrData[1:0] != 2'b11
      |=> m0 == $past(regWrData[1:0]))
      else $error("mode write not taken");

   a_traffic_intact: assert property (
      q.cuSync[0] && q.fiSync[0] && $stable(q.cuSync[0]) && $stable(q.fiSync[0])
      ##1 q.cuSync[0] && q.fiSync[0] |=> cuTxEn[0] && fiTxEn[0])
      else $error("transmitter altered with both links up");

   a_display_leds: assert property (
      m0 == CFLP_MODE_DISPLAY
      |=> cuLinkLed[0] == $past(q.cuSync[0]) && fiLinkLed[0] == $past(q.fiSync[0]))
      else $error("display LEDs do not follow own link");

   a_silence_cu: assert property (
      m0 == CFLP_MODE_LOSS_SILENCE && !q.cuSync[0] |=> !fiTxEn[0])
      else $error("fiber transmitter not silenced");

   a_silence_fi: assert property (
      m0 == CFLP_MODE_LOSS_SILENCE && !q.fiSync[0] |=> !cuTxEn[0])
      else $error("copper transmitter not silenced");

   a_silence_leds: assert property (
      m0 == CFLP_MODE_LOSS_SILENCE |=> cuLinkLed[0] == fiLinkLed[0]
      && cuLinkLed[0] == ($past(q.cuSync[0]) && $past(q.fiSync[0])))
      else $error("silence LEDs not in tandem");

   a_pulse_fiber: assert property (
      m0 == CFLP_MODE_LOSS_PULSE && !q.cuSync[0] && q.fiSync[0]
      |=> fiTxEn[0] == $past(blinkPh[0]) && fiLinkLed[0] == $past(blinkPh[0]))
      else $error("fiber side not pulsing");

   // Fiber loss: copper side pulses, fiber side stays enabled and dark
   a_pulse_copper: assert property (
      m0 == CFLP_MODE_LOSS_PULSE && q.cuSync[0] && !q.fiSync[0]
      |=> cuTxEn[0] == $past(blinkPh[0]) && cuLinkLed[0] == $past(blinkPh[0])
      && fiTxEn[0] && !fiLinkLed[0])
      else $error("copper side not pulsing");

   // Mode only moves on a register write or a button edge
   a_mode_hold: assert property (
      !regWrite && !(q.btnSync[0] && !q.btnPrev[0]) |=> $stable(m0))
      else $error("mode changed without a request");

   a_pulse_resume: assert property (
      m0 == CFLP_MODE_LOSS_PULSE && q.cuSync[0] && q.fiSync[0]
      |=> cuTxEn[0] && fiTxEn[0] && cuLinkLed[0] && fiLinkLed[0])
      else $error("pulse mode did not resume");

   // Skip the two edges after release, while the sync stages still hold reset
   a_link_sync: assert property (
      $past(rst_n) && $past(rst_n, 2) |-> q.cuSync[0] == $past(cuLinkIn[0], 2))
      else $error("copper link not two-stage synced");

endmodule // channel_link_fault_passthrough
`default_nettype wire

// *** testbench/cflp_far_end.sv ***
// Far-side network devices on the copper and fiber links of every channel
`timescale 1ns/1ns
`default_nettype none
module cflp_far_end
   import cflp_pkg::*;
#(
   parameter int NUM_CH = CFLP_NUM_CH
)(
   // Cable state set by the bench
   input  wire logic [NUM_CH-1:0] cuPlug,
   input  wire logic [NUM_CH-1:0] fiPlug,
   // Our transmitters as the far devices see them
   input  wire logic [NUM_CH-1:0] cuTxEn,
   input  wire logic [NUM_CH-1:0] fiTxEn,
   // Link seen by our PHYs and by the far devices
   output var  logic [NUM_CH-1:0] cuLinkIn,
   output var  logic [NUM_CH-1:0] fiLinkIn,
   output var  logic [NUM_CH-1:0] cuFarUp,
   output var  logic [NUM_CH-1:0] fiFarUp
);
   // ------------------------------------------------------------
   // Link logic
   // ------------------------------------------------------------
   // Far devices always transmit, so our PHY link follows the cable
   assign cuLinkIn = cuPlug;
   assign fiLinkIn = fiPlug;
   // A far device loses link when our transmitter goes quiet
   assign cuFarUp  = cuPlug & cuTxEn;
   assign fiFarUp  = fiPlug & fiTxEn;
endmodule // cflp_far_end
`default_nettype wire

// *** testbench/tb_channel_link_fault_passthrough.sv ***
// Self-checking bench for the link-fault pass-through controller
`timescale 1ns/1ns
`default_nettype none
module tb_channel_link_fault_passthrough
   import cflp_pkg::*;
;
   localparam int HC = 4;
   logic        ref_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic [7:0]  regAddr   = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic        regWrite  = 1'b0;
   logic        regRead   = 1'b0;
   logic [11:0] modeBtnIn = 12'h000;
   logic [11:0] cuPlug    = 12'hfff;
   logic [11:0] fiPlug    = 12'hfff;
   logic [31:0] regRdData, rdQ;
   logic        irq;
   logic [11:0] cuLinkIn, fiLinkIn, cuTxEn, fiTxEn, cuLinkLed, fiLinkLed, cuFarUp, fiFarUp;
   int          n_errors  = 0;
   int          n_checks  = 0;

   // Free-running system clock
   always #20 ref_clk = ~ref_clk;

   channel_link_fault_passthrough #(.NUM_CH(12), .HALF_CYC(HC)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .irq(irq),
      .cuLinkIn(cuLinkIn), .fiLinkIn(fiLinkIn), .modeBtnIn(modeBtnIn),
      .cuTxEn(cuTxEn), .fiTxEn(fiTxEn), .cuLinkLed(cuLinkLed), .fiLinkLed(fiLinkLed));

   cflp_far_end #(.NUM_CH(12)) far (
      .cuPlug(cuPlug), .fiPlug(fiPlug), .cuTxEn(cuTxEn), .fiTxEn(fiTxEn),
      .cuLinkIn(cuLinkIn), .fiLinkIn(fiLinkIn), .cuFarUp(cuFarUp), .fiFarUp(fiFarUp));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite  <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(negedge ref_clk);
      rdQ = regRdData;
   endtask

   // Sync plus output flop needs 3 edges; 4 leaves margin
   task automatic link(input logic [11:0] cu, input logic [11:0] fi);
      @(posedge ref_clk);
      cuPlug <= cu;
      fiPlug <= fi;
      wt(4);
   endtask

   // Order: copper tx, fiber tx, copper LED, fiber LED
   task automatic ch(input int c, input logic [3:0] e, input string nm);
      check(nm, {cuTxEn[c], fiTxEn[c], cuLinkLed[c], fiLinkLed[c]}, e);
   endtask

   // Any window of two periods holds exactly one period of on-time
   task automatic blink(input int c, input bit onFi);
      int nTx, nLed, nDead;
      nTx = 0;
      nLed = 0;
      nDead = 0;
      repeat (4*HC)
      begin
         @(negedge ref_clk);
         nTx   += onFi ? fiTxEn[c] : cuTxEn[c];
         nLed  += (onFi ? fiLinkLed[c] : cuLinkLed[c]) === (onFi ? fiTxEn[c] : cuTxEn[c]);
         nDead += onFi ? cuLinkLed[c] : fiLinkLed[c];
      end
      check("blink tx", nTx, 2*HC);
      check("blink led", nLed, 4*HC);
      check("dead led", nDead, 0);
   endtask

   task automatic press(input int c);
      @(posedge ref_clk);
      modeBtnIn[c] <= 1'b1;
      wt(4);
      @(posedge ref_clk);
      modeBtnIn[c] <= 1'b0;
      wt(4);
   endtask

   task automatic test_done;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   // Hang guard, well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (4000) @(posedge ref_clk);
      n_errors++;
      test_done;
   end

   initial
   begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      wt(4);
      rd(CFLP_ADDR_EVENT);
      rd(CFLP_ADDR_MODE);
      check("mode rst", rdQ, CFLP_RESET_WORD);
      rd(CFLP_ADDR_MASK);
      check("mask rst", rdQ, CFLP_RESET_WORD);
      rd(CFLP_ADDR_LINK);
      check("link reg", rdQ, 32'h0fff_0fff);
      rd(8'h10);
      check("unmapped", rdQ, 32'h0);
      check("tx all on", {cuTxEn, fiTxEn}, 32'h00ff_ffff);
      // Display mode, one side at a time
      link(12'hffe, 12'hfff);
      ch(0, 4'b1101, "disp cu down");
      link(12'hfff, 12'hffe);
      ch(0, 4'b1110, "disp fi down");
      // Ch0 silence, ch1 pulse, ch2 illegal code refused
      wr(CFLP_ADDR_MODE, 32'h0000_0039);
      rd(CFLP_ADDR_MODE);
      check("mode set", rdQ, 32'h0000_0009);
      link(12'hffa, 12'hfff);
      ch(0, 4'b1000, "sil cu down");
      check("far fi", fiFarUp[0], 1'b0);
      ch(2, 4'b1101, "other ch");
      link(12'hfff, 12'hfff);
      ch(0, 4'b1111, "sil relink");
      link(12'hfff, 12'hffe);
      ch(0, 4'b0100, "sil fi down");
      check("far cu", cuFarUp[0], 1'b0);
      link(12'hfff, 12'hfff);
      ch(0, 4'b1111, "sil back");
      // Ch0 joins ch1 in pulse mode; ch0 is blink-checked only with its fiber side pulsing
      wr(CFLP_ADDR_MODE, 32'h0000_000a);
      rd(CFLP_ADDR_MODE);
      check("mode pulse", rdQ, 32'h0000_000a);
      link(12'hfff, 12'hffc);
      blink(1, 1'b0);
      link(12'hffc, 12'hfff);
      blink(1, 1'b1);
      blink(0, 1'b1);
      link(12'hfff, 12'hfff);
      ch(1, 4'b1111, "pulse end");
      ch(0, 4'b1111, "pulse end ch0");
      // Interrupt raise, clear and mask
      rd(CFLP_ADDR_EVENT);
      wr(CFLP_ADDR_MASK, 32'h1);
      rd(CFLP_ADDR_MASK);
      check("mask rw", rdQ, 32'h1);
      check("irq idle", irq, 1'b0);
      link(12'hffe, 12'hfff);
      check("irq set", irq, 1'b1);
      rd(CFLP_ADDR_EVENT);
      check("event", rdQ, 32'h1);
      check("irq clr", irq, 1'b0);
      link(12'hfff, 12'hfff);
      rd(CFLP_ADDR_EVENT);
      wr(CFLP_ADDR_MASK, 32'h0);
      link(12'hff7, 12'hfff);
      check("irq masked", irq, 1'b0);
      rd(CFLP_ADDR_EVENT);
      check("event ch3", rdQ, 32'h8);
      link(12'hfff, 12'hfff);
      // Panel button steps ch4 through all three modes
      for (int k = 1; k <= 3; k++)
      begin
         press(4);
         rd(CFLP_ADDR_MODE);
         check("btn mode", rdQ, 32'ha | ((k % 3) << 8));
      end
      test_done;
   end
endmodule // tb_channel_link_fault_passthrough
`default_nettype wire
